// ===== pci_rcc_defines.svh
`ifndef PCI_RCC_DEFINES_SVH
`define PCI_RCC_DEFINES_SVH

// ----------------------------------------------------------------
// system control register
// ----------------------------------------------------------------
`define SYSCTL_OFFSET 8'h80
`define KEEP_CLOCK_RUNNING_BIT_BIT 1
`define PME_EN_BIT 8
`define SYSCTL_RESET 32'h0000_0002
`define SYSCTL_RW_MASK 32'h0000_0102
`define PME_STS_MASK 32'h0000_8000
`define CLK_STOPPED_MASK 32'h0001_0000
`define WORD_ZERO 32'h0000_0000

// ----------------------------------------------------------------
// pin synchroniser: {suspend_n, bus_reset_in_n, clkrun_n}
// ----------------------------------------------------------------
`define SYNC_RESET 3'h4
`define SYNC_CLKRUN 0
`define SYNC_BUSRST 1
`define SYNC_SUSPEND 2

// ----------------------------------------------------------------
// clock-run response
// ----------------------------------------------------------------
`define CLKRUN_HOLD 2'h2
`define CLKRUN_LAST 2'h1
`define HOLD_ZERO 2'h0

`endif

// ===== pci_rcc_pkg.sv
package pci_rcc_pkg;

    typedef enum logic [1:0] {CR_RUN, CR_HOLD, CR_STOPPED} clkrun_state_t;

    typedef logic [31:0] word_t;

    // byte enables widened to a bit mask, shared by rw and w1c merges
    function automatic word_t be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

endpackage

// ===== clkrun_if.sv
`timescale 1ns/1ps

interface clkrun_if;
    logic req_n_s;
    logic keep;
    logic need;
    logic quiet;
    logic drive_low;
    logic stopped;

    modport ctrl(output req_n_s, keep, need, quiet,
                 input drive_low, stopped);
    modport resp(input req_n_s, keep, need, quiet,
                 output drive_low, stopped);
endinterface

// ===== clkrun_responder.sv
`timescale 1ns/1ps
`include "pci_rcc_defines.svh"

module clkrun_responder (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // control side
    clkrun_if.resp cr
);

    pci_rcc_pkg::clkrun_state_t state_q;
    pci_rcc_pkg::clkrun_state_t state_d;
    logic [1:0] hold_q;
    logic [1:0] hold_d;
    logic prev_q;

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    // a rising clock-run line is the central resource asking to stop
    wire stop_req = cr.req_n_s & ~prev_q;
    wire want_clk = cr.keep | cr.need;

    always_comb begin
        state_d = state_q;
        hold_d = hold_q;
        if (cr.quiet) begin
            state_d = pci_rcc_pkg::CR_RUN;
            hold_d = `HOLD_ZERO;
        end else begin
            unique case (state_q)
                pci_rcc_pkg::CR_RUN: begin
                    if (stop_req && want_clk) begin
                        state_d = pci_rcc_pkg::CR_HOLD;
                        hold_d = `CLKRUN_HOLD;
                    end else if (stop_req) begin
                        state_d = pci_rcc_pkg::CR_STOPPED;
                    end
                end
                pci_rcc_pkg::CR_HOLD: begin
                    hold_d = hold_q - `CLKRUN_LAST;
                    if (hold_q == `CLKRUN_LAST) begin
                        state_d = pci_rcc_pkg::CR_RUN;
                    end
                end
                pci_rcc_pkg::CR_STOPPED: begin
                    // a slowed clock still ticks, so a restart can be asked
                    if (!cr.req_n_s) begin
                        state_d = pci_rcc_pkg::CR_RUN;
                    end else if (cr.need) begin
                        state_d = pci_rcc_pkg::CR_HOLD;
                        hold_d = `CLKRUN_HOLD;
                    end
                end
                default: begin
                    state_d = pci_rcc_pkg::CR_RUN;
                    hold_d = `HOLD_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= pci_rcc_pkg::CR_RUN;
            hold_q <= `HOLD_ZERO;
            prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            hold_q <= hold_d;
            prev_q <= cr.req_n_s;
        end
    end

    assign cr.drive_low = (state_q == pci_rcc_pkg::CR_HOLD);
    assign cr.stopped = (state_q == pci_rcc_pkg::CR_STOPPED);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_HOLD_TWO: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (state_q == pci_rcc_pkg::CR_RUN && stop_req && want_clk && !cr.quiet)
        ##1 (!cr.quiet) [*3] |-> !cr.drive_low && $past(cr.drive_low)
        && $past(cr.drive_low, 2))
        else $error("stop request not held off for two cycles");

    AST_HOLD_END: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (cr.drive_low && hold_q == `CLKRUN_LAST && !cr.quiet)
        |=> !cr.drive_low)
        else $error("clock-run drive not released");

    AST_STOP_GRANT: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (state_q == pci_rcc_pkg::CR_RUN && stop_req && !want_clk && !cr.quiet)
        |=> cr.stopped && !cr.drive_low)
        else $error("stop request not granted");

    AST_QUIET: assert property (
        @(posedge mclk) disable iff (!reset_n)
        cr.quiet |=> !cr.drive_low && !cr.stopped)
        else $error("clock-run active while held quiet");

endmodule // clkrun_responder

// ===== pci_reset_clock_control.sv
`timescale 1ns/1ps
`include "pci_rcc_defines.svh"


module pci_reset_clock_control (
    // clock and global reset (the global reset pin)
    input wire logic mclk,
    input wire logic reset_n,
    // bus pins
    input wire logic bus_reset_in_n,
    input wire logic suspend_n,
    input wire logic clkrun_n_in,
    output logic clkrun_n_out,
    output logic clkrun_n_oe,
    output logic pme_n_out,
    output logic pme_n_oe,
    // configuration access
    input wire logic cfg_sel,
    input wire logic cfg_we,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    // device core
    input wire logic clk_needed,
    input wire logic pme_event
);

    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    pci_rcc_pkg::word_t sysctl_q;
    pci_rcc_pkg::word_t sysctl_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic ack_q;

    clkrun_if cr();

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= `SYNC_RESET;
            sync2_q <= `SYNC_RESET;
        end else begin
            sync1_q <= {suspend_n, bus_reset_in_n, clkrun_n_in};
            sync2_q <= sync1_q;
        end
    end

    wire bus_rst_s = ~sync2_q[`SYNC_BUSRST];
    wire susp_s = ~sync2_q[`SYNC_SUSPEND];
    wire func = ~bus_rst_s;
    // suspend shields the registers from bus reset only
    wire clear_regs = bus_rst_s & ~susp_s;

    // ----------------------------------------------------------------
    // configuration decode
    // ----------------------------------------------------------------
    wire cfg_hit = (cfg_addr == `SYSCTL_OFFSET);
    wire take = func & cfg_sel;
    wire wr_hit = take & cfg_we & cfg_hit;
    wire rd_hit = take & ~cfg_we & cfg_hit;
    wire [31:0] bmask = pci_rcc_pkg::be_mask(cfg_be);
    wire [31:0] rw_bits = bmask & `SYSCTL_RW_MASK;
    wire [31:0] rw_new = (sysctl_q & ~rw_bits) | (cfg_wdata & rw_bits);
    wire [31:0] w1c_clr = wr_hit ?
        (cfg_wdata & bmask & `PME_STS_MASK) : `WORD_ZERO;
    wire [31:0] pme_set = (func & pme_event) ? `PME_STS_MASK : `WORD_ZERO;
    wire [31:0] wr_val = wr_hit ? rw_new : sysctl_q;
    wire [31:0] stop_view = cr.stopped ? `CLK_STOPPED_MASK : `WORD_ZERO;
    wire [31:0] read_val = sysctl_q | stop_view;
    wire keep_clock_running_bit = sysctl_q[`KEEP_CLOCK_RUNNING_BIT_BIT];
    wire pme_enable = sysctl_q[`PME_EN_BIT];
    wire pme_status = |(sysctl_q & `PME_STS_MASK);

    // ----------------------------------------------------------------
    // system control register
    // ----------------------------------------------------------------
    always_comb begin
        if (clear_regs) begin
            sysctl_d = `SYSCTL_RESET;
        end else if (bus_rst_s) begin
            sysctl_d = sysctl_q;
        end else begin
            // set after clear: a wake event in the clearing cycle survives
            sysctl_d = (wr_val & ~w1c_clr) | pme_set;
        end
    end

    assign rdata_d = rd_hit ? read_val : `WORD_ZERO;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sysctl_q <= `SYSCTL_RESET;
            rdata_q <= `WORD_ZERO;
            ack_q <= 1'b0;
        end else begin
            sysctl_q <= sysctl_d;
            rdata_q <= rdata_d;
            ack_q <= take;
        end
    end

    // ----------------------------------------------------------------
    // clock-run responder
    // ----------------------------------------------------------------
    assign cr.req_n_s = sync2_q[`SYNC_CLKRUN];
    assign cr.keep = keep_clock_running_bit;
    assign cr.need = clk_needed;
    assign cr.quiet = bus_rst_s;

    clkrun_responder u_clkrun (
        .mclk(mclk),
        .reset_n(reset_n),
        .cr(cr.resp)
    );

    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    // open-drain pins only ever pull low; the enable is the signal
    assign clkrun_n_out = 1'b0;
    assign pme_n_out = 1'b0;
    assign clkrun_n_oe = cr.drive_low & func;
    assign pme_n_oe = pme_status & pme_enable & func;
    assign cfg_rdata = rdata_q;
    assign cfg_ack = ack_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_OUTPUTS_FLOAT: assert property (
        @(posedge mclk) disable iff (!reset_n)
        bus_rst_s |-> !clkrun_n_oe && !pme_n_oe)
        else $error("output driven during bus reset");

    AST_NO_FUNCTION: assert property (
        @(posedge mclk) disable iff (!reset_n)
        bus_rst_s |=> !cfg_ack && cfg_rdata == `WORD_ZERO)
        else $error("access answered during bus reset");

    AST_BUSRST_CLEARS: assert property (
        @(posedge mclk) disable iff (!reset_n)
        clear_regs |=> sysctl_q == `SYSCTL_RESET)
        else $error("bus reset left a register dirty");

    AST_SUSPEND_KEEPS: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (bus_rst_s && susp_s) |=> $stable(sysctl_q))
        else $error("suspend did not preserve registers");

    AST_PME_SET_WINS: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (func && pme_event) |=> pme_status)
        else $error("wake event lost");

    AST_PME_PIN: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (func && pme_status && pme_enable) |-> pme_n_oe)
        else $error("wake pin not driven");

    AST_READ_BACK: assert property (
        @(posedge mclk) disable iff (!reset_n)
        rd_hit |=> cfg_ack && cfg_rdata == $past(read_val))
        else $error("system control read mismatch");

    AST_KEEP_FEEDS: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (wr_hit && cfg_be[0]) |=>
        keep_clock_running_bit == $past(cfg_wdata[`KEEP_CLOCK_RUNNING_BIT_BIT]))
        else $error("keep-clock bit not written");

    AST_UNMAPPED: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (take && !cfg_hit) |=> cfg_ack && cfg_rdata == `WORD_ZERO
        && $stable(sysctl_q & `SYSCTL_RW_MASK))
        else $error("unmapped access misbehaved");

    AST_ACK_NEXT: assert property (
        @(posedge mclk) disable iff (!reset_n)
        take |=> cfg_ack)
        else $error("taken access not acknowledged");

    AST_ACK_ONLY: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !take |=> !cfg_ack && cfg_rdata == `WORD_ZERO)
        else $error("acknowledge without a taken access");

    AST_PME_CLEAR: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (wr_hit && !pme_event && |(bmask & cfg_wdata & `PME_STS_MASK))
        |=> !pme_status)
        else $error("wake status not cleared by write");

    AST_PME_HOLD: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (!pme_event && !wr_hit && !clear_regs) |=> $stable(pme_status))
        else $error("wake status changed on its own");

    AST_STOP_VIEW: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (rd_hit && cr.stopped) |=> |(cfg_rdata & `CLK_STOPPED_MASK))
        else $error("stopped clock not reported");

    AST_BUSRST_SEEN: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (!bus_reset_in_n) [*3] |-> bus_rst_s)
        else $error("bus reset not seen after two flops");

    AST_BUSRST_GONE: assert property (
        @(posedge mclk) disable iff (!reset_n)
        bus_reset_in_n [*3] |-> !bus_rst_s)
        else $error("bus reset release not seen after two flops");

    AST_KEEP_DEFAULT: assert property (
        @(posedge mclk) disable iff (!reset_n)
        clear_regs |=> keep_clock_running_bit)
        else $error("keep-clock bit not set by bus reset");

endmodule // pci_reset_clock_control

// ===== clk_resource_model.sv
`timescale 1ns/1ps

// ----
// host system and central clock resource
// ----
module clk_resource_model (
    // clock
    input wire logic mclk,
    // bench requests
    input wire logic stop_req,
    input wire logic rst_req,
    input wire logic susp_req,
    // device pins
    input wire logic clkrun_n_oe,
    input wire logic clkrun_n_out,
    output logic bus_reset_in_n,
    output logic suspend_n,
    output logic clkrun_n_in
);
    logic pull_q;
    initial begin
        pull_q = 1'b1;
        bus_reset_in_n = 1'b0;
        suspend_n = 1'b1;
    end
    // global reset stays with the bench, at boot and once more in t_resets; here only bus reset
    always @(posedge mclk) begin
        #1;
        bus_reset_in_n = ~rst_req;
        suspend_n = ~susp_req;
        pull_q = ~stop_req;
    end
    // pulled-up line: low while either side pulls it
    assign clkrun_n_in = ~(pull_q | (clkrun_n_oe & ~clkrun_n_out));
endmodule // clk_resource_model

// ===== pci_reset_clock_control_tb.sv
`timescale 1ns/1ps

module pci_reset_clock_control_tb;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic stop_req = 1'b0, rst_req = 1'b0, susp_req = 1'b0;
    logic bus_reset_in_n, suspend_n, clkrun_n_in;
    logic clkrun_n_out, clkrun_n_oe, pme_n_out, pme_n_oe;
    logic cfg_sel = 1'b0, cfg_we = 1'b0, cfg_ack;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
    logic clk_needed = 1'b0, pme_event = 1'b0;
    int n_mismatch = 0, comparisons = 0;

    always #12.5 mclk = ~mclk;

    pci_reset_clock_control dut (.mclk, .reset_n, .bus_reset_in_n,
        .suspend_n, .clkrun_n_in, .clkrun_n_out, .clkrun_n_oe, .pme_n_out,
        .pme_n_oe, .cfg_sel, .cfg_we, .cfg_addr, .cfg_be, .cfg_wdata,
        .cfg_rdata, .cfg_ack, .clk_needed, .pme_event);

    clk_resource_model host (.mclk, .stop_req, .rst_req, .susp_req,
        .clkrun_n_oe, .clkrun_n_out, .bus_reset_in_n, .suspend_n,
        .clkrun_n_in);

    // ----
    // shared tasks
    // ----
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cfg(input logic we, input logic [7:0] a,
            input logic [3:0] be, input logic [31:0] wd,
            output logic ak, output logic [31:0] rd);
        cfg_sel = 1'b1;
        cfg_we = we;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = wd;
        tick(1);
        ak = cfg_ack;
        rd = cfg_rdata;
        cfg_sel = 1'b0;
        // one idle edge so a following call never re-raises the strobe at once
        tick(1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic ak;
        logic [31:0] rd;
        cfg(1'b1, a, 4'hf, wd, ak, rd);
        check(32'(ak), 32'h1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic ak;
        logic [31:0] rd;
        cfg(1'b0, a, 4'h0, 32'h0, ak, rd);
        check(32'(ak), 32'h1);
        check(rd, exp);
    endtask

    // bounded wait for a drive, then its length in cycles
    task automatic pulse(output int w);
        int i;
        w = 0;
        for (i = 0; i < 12 && clkrun_n_oe !== 1'b1; i++) tick(1);
        while (clkrun_n_oe === 1'b1 && w < 8) begin
            w++;
            tick(1);
        end
    endtask

    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_regs();
        logic ak;
        logic [31:0] rd;
        check(32'({clkrun_n_oe, pme_n_oe}), 32'h0);
        reset_n = 1'b1;
        tick(5);
        check(32'({clkrun_n_out, pme_n_out}), 32'h0);
        rd_chk(8'h80, 32'h2);
        rd_chk(8'h84, 32'h0);
        wr(8'h80, 32'hffff_ffff);
        rd_chk(8'h80, 32'h102);
        cfg(1'b1, 8'h80, 4'h1, 32'h0, ak, rd);
        check(32'(ak), 32'h1);
        rd_chk(8'h80, 32'h100);
    endtask

    task automatic t_clkrun();
        int w;
        wr(8'h80, 32'h2);
        stop_req = 1'b1;
        pulse(w);
        check(32'(w), 32'h2);
        stop_req = 1'b0;
        tick(8);
        wr(8'h80, 32'h0);
        stop_req = 1'b1;
        tick(8);
        rd_chk(8'h80, 32'h0001_0000);
        clk_needed = 1'b1;
        pulse(w);
        check(32'(w), 32'h2);
        clk_needed = 1'b0;
        stop_req = 1'b0;
        tick(8);
    endtask

    task automatic t_resets();
        logic ak;
        logic [31:0] rd;
        wr(8'h80, 32'h100);
        pme_event = 1'b1;
        tick(1);
        pme_event = 1'b0;
        check(32'(pme_n_oe), 32'h1);
        susp_req = 1'b1;
        rst_req = 1'b1;
        tick(4);
        check(32'({clkrun_n_oe, pme_n_oe}), 32'h0);
        cfg(1'b1, 8'h80, 4'hf, 32'h2, ak, rd);
        check(32'(ak), 32'h0);
        rst_req = 1'b0;
        tick(5);
        susp_req = 1'b0;
        tick(4);
        rd_chk(8'h80, 32'h8100);
        wr(8'h80, 32'h0000_8000);
        pme_event = 1'b1;
        tick(1);
        pme_event = 1'b0;
        check(32'(pme_n_oe), 32'h0);
        rd_chk(8'h80, 32'h0000_8000);
        rst_req = 1'b1;
        tick(4);
        check(32'(pme_n_oe), 32'h0);
        rst_req = 1'b0;
        tick(5);
        rd_chk(8'h80, 32'h2);
        wr(8'h80, 32'h100);
        pme_event = 1'b1;
        tick(1);
        pme_event = 1'b0;
        susp_req = 1'b1;
        reset_n = 1'b0;
        tick(2);
        check(32'({clkrun_n_oe, pme_n_oe}), 32'h0);
        reset_n = 1'b1;
        tick(5);
        rd_chk(8'h80, 32'h2);
        susp_req = 1'b0;
    endtask

    initial begin
        tick(5);
        t_regs();
        t_clkrun();
        t_resets();
        stop_test();
    end

    // a hang counts as a mismatch
    initial begin
        #500000;
        n_mismatch++;
        stop_test();
    end
endmodule // pci_reset_clock_control_tb
